/* File: core/epf_pkg.sv */
/*
 * Constants for the page-frame map configuration block: port numbers,
 * configuration indices, field positions, reset values and address figures.
 * Assumes byte-wide processor I/O cycles and a 16 MB physical address space.
 */
package epf_pkg;

   // ****************************************
   // Processor ports
   // ****************************************
   localparam logic [15:0] CFG_INDEX_PORT  = 16'h0022;
   localparam logic [15:0] CFG_DATA_PORT   = 16'h0023;
   localparam logic [15:0] PAGE_PORT_BASE  = 16'h0208;
   localparam logic [15:0] PAGE_PORT_MASK  = 16'hFFFE;
   localparam logic [15:0] PAGE_PORT_DATA  = 16'h0001;

   // ****************************************
   // Configuration indices
   // ****************************************
   localparam logic [7:0] IDX_DRAM_CONFIG_EMS_ENABLE   = 8'h6B;
   localparam logic [7:0] IDX_EMS_FRAME_AND_IO_BASE    = 8'h6D;
   localparam logic [7:0] IDX_EMS_PAGE_RANGE_EXTENSION = 8'h6E;
   localparam logic [7:0] IDX_MISC_EMS_SIZE            = 8'h6F;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int EMS_ENABLE_BIT = 4;
   localparam int SIZE_LSB       = 5;
   localparam int FRAME_LSB      = 4;
   localparam int IO_LSB         = 0;
   localparam logic [7:0] CFG_RESET      = 8'h00;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;

   // ****************************************
   // Address figures
   // ****************************************
   localparam logic [3:0]  FRAME_CODE_MAX = 4'h8;
   localparam logic [19:0] FRAME_PHYS_LO  = 20'hC0000;
   localparam logic [19:0] FRAME_STEP     = 20'h04000;
   localparam logic [19:0] FRAME_SPAN     = 20'h10000;
   localparam logic [23:0] ONE_MB         = 24'h100000;
   localparam logic [23:0] HALF_MB        = 24'h080000;
   localparam logic [23:0] DRAM_LIMIT     = 24'h800000;
   localparam int          PAGE_SHIFT     = 14;
   localparam int          PAGE_COUNT     = 4;
   localparam logic [15:0] IO_CODE_VALID  = 16'h4C63;

   typedef enum logic [1:0] {
      IDX_EMPTY = 2'b01,
      IDX_ARMED = 2'b10
   } epf_idx_state_t;

endpackage

/* File: core/epf_page_mem.sv */
/*
 * Four page registers of the expanded-memory frame.
 * Assumes one write port and two read ports; read data come from flip-flops.
 */
`timescale 1ns/1ns
`default_nettype none

module epf_page_mem
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       wr_en,
   input  wire logic [1:0] wr_sel,
   input  wire logic [7:0] wr_data,
   input  wire logic [1:0] rd_a_sel,
   output logic      [7:0] rd_a_data,
   input  wire logic [1:0] rd_b_sel,
   output logic      [7:0] rd_b_data
);
   import epf_pkg::*;

   logic [7:0] page_q [PAGE_COUNT];

   // ****************************************
   // Storage
   // ****************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < PAGE_COUNT; i++)
            page_q[i] <= CFG_RESET;
      end
      else if (wr_en)
         page_q[wr_sel] <= wr_data;
   end

   // ****************************************
   // Registered reads
   // ****************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_a_data <= CFG_RESET;
         rd_b_data <= CFG_RESET;
      end
      else
      begin
         rd_a_data <= page_q[rd_a_sel];
         rd_b_data <= page_q[rd_b_sel];
      end
   end

endmodule

`default_nettype wire

/* File: core/epf_map_cfg.sv */
/*
 * Expanded-memory page-frame configuration and address mapper.
 * Assumes one-cycle I/O strobes synchronous to SYS_CLK and a memory address
 * presented with a one-cycle valid strobe; mapped address follows two edges later.
 */
`timescale 1ns/1ns
`default_nettype none

// How it works
// R1: Bit 4 of index 6BH enables mapping
// R2: Index 6FH bits 7-5 hold size
// R3: First megabyte stays system; rest is expanded
// R4: Index 6DH bits 7-4 select frame base
// R5: Frame is four consecutive 16K pages
// R6: Page 0 at C000H plus code times 400H
// R7: Index 6EH bits 7-6 give page 0 range
// R8: Pages 1-3 use bits 5-4, 3-2, 1-0
// R9: Software keeps ranges inside installed memory
// R10: Index 6DH bits 3-0 pick page port pair
// R11: Page registers answer only at selected pair
// R12: Up to 8 MB, above 1 MB mapped
// R13: Index write precedes every data access
// R14: Enabled frame hits redirect, others pass through
// R15: Reserved base or port codes disable decode
module epf_map_cfg
(
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   input  wire logic [15:0] IO_ADDR,
   input  wire logic        IO_WR,
   input  wire logic        IO_RD,
   input  wire logic [7:0]  IO_WDATA,
   output logic      [7:0]  IO_RDATA,
   output logic             IO_ACK,
   input  wire logic [23:0] MEM_ADDR,
   input  wire logic        MEM_VALID,
   output logic      [23:0] MAP_ADDR,
   output logic             MAP_VALID,
   output logic             MAP_HIT
);
   import epf_pkg::*;

   epf_idx_state_t idx_state_q;
   logic [7:0]  index_q;
   logic [7:0]  cfg_enable_q;
   logic [7:0]  cfg_frame_io_q;
   logic [7:0]  cfg_range_q;
   logic [7:0]  cfg_size_q;
   logic [1:0]  page_sel_q;
   logic [23:0] addr_s1_q;
   logic        valid_s1_q;
   logic        hit_s1_q;
   logic [1:0]  page_s1_q;
   logic        page_rd_q;
   logic [7:0]  cfg_rd_q;
   logic [7:0]  page_a_data;
   logic [7:0]  page_b_data;

   function automatic logic io_code_ok(input logic [3:0] code);
      io_code_ok = IO_CODE_VALID[code];
   endfunction

   function automatic logic [23:0] range_base(input logic [1:0] code);
      case (code)
         2'b00:   range_base = ONE_MB;
         2'b01:   range_base = 24'h200000;
         2'b10:   range_base = 24'h400000;
         2'b11:   range_base = 24'h600000;
         default: range_base = ONE_MB;
      endcase
   endfunction

   // ****************************************
   // Decodes
   // ****************************************
   logic        is_idx_wr;
   logic        is_data;
   logic        data_ok;
   logic [3:0]  frame_code;
   logic [3:0]  io_code;
   logic        decode_ok;
   logic [15:0] page_port;
   logic        page_io;
   logic        page_wr_sel;
   logic        page_wr_data;
   logic [19:0] frame_lo;
   logic [19:0] frame_off;
   logic        in_frame;
   logic [1:0]  s1_ext;
   logic [23:0] mapped;
   logic [23:0] ems_limit;

   assign is_idx_wr    = IO_WR && (IO_ADDR == CFG_INDEX_PORT);
   assign is_data      = (IO_WR || IO_RD) && (IO_ADDR == CFG_DATA_PORT);
   assign data_ok      = is_data && (idx_state_q == IDX_ARMED);
   assign frame_code   = cfg_frame_io_q[FRAME_LSB +: 4];                     // [R4]
   assign io_code      = cfg_frame_io_q[IO_LSB +: 4];                        // [R10]
   // Reserved codes shut both frame decode and page ports
   assign decode_ok    = (frame_code <= FRAME_CODE_MAX) && io_code_ok(io_code); // [R15]
   assign page_port    = PAGE_PORT_BASE | {8'h00, io_code, 4'h0};           // [R10]
   assign page_io      = decode_ok && ((IO_ADDR & PAGE_PORT_MASK) == page_port); // [R11]
   assign page_wr_sel  = page_io && IO_WR && !IO_ADDR[0];
   assign page_wr_data = page_io && IO_WR && (IO_ADDR[0] == PAGE_PORT_DATA[0]);
   assign frame_lo     = FRAME_PHYS_LO + 20'(frame_code) * FRAME_STEP;     // [R6]
   assign frame_off    = MEM_ADDR[19:0] - frame_lo;
   assign in_frame     = (MEM_ADDR[23:20] == 4'h0) && (MEM_ADDR[19:0] >= frame_lo)
                         && (frame_off < FRAME_SPAN);                        // [R5]
   assign s1_ext       = cfg_range_q[2 * (3 - page_s1_q) +: 2];             // [R7] [R8]
   // Page number scaled to 16K, offset inside the page kept
   assign mapped       = range_base(s1_ext) + {3'b000, page_b_data[6:0], addr_s1_q[13:0]}; // [R12]
   assign ems_limit    = (cfg_size_q[SIZE_LSB +: 3] == 3'b000) ? (ONE_MB + HALF_MB)
                         : ONE_MB + {cfg_size_q[SIZE_LSB +: 3], 20'h00000};  // [R2] [R3]

   // ****************************************
   // Index sequencing
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         idx_state_q <= IDX_EMPTY;
         index_q     <= CFG_RESET;
      end
      else if (is_idx_wr)
      begin
         idx_state_q <= IDX_ARMED;
         index_q     <= IO_WDATA;
      end
      else if (is_data)
         idx_state_q <= IDX_EMPTY;                                           // [R13]
      else
      begin
         case (idx_state_q)
            IDX_EMPTY: idx_state_q <= IDX_EMPTY;
            IDX_ARMED: idx_state_q <= IDX_ARMED;
            default:   idx_state_q <= IDX_EMPTY;
         endcase
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cfg_enable_q   <= CFG_RESET;
         cfg_frame_io_q <= CFG_RESET;
         cfg_range_q    <= CFG_RESET;
         cfg_size_q     <= CFG_RESET;
      end
      else if (data_ok && IO_WR)
      begin
         case (index_q)
            IDX_DRAM_CONFIG_EMS_ENABLE:   cfg_enable_q   <= IO_WDATA;         // [R1]
            IDX_EMS_FRAME_AND_IO_BASE:    cfg_frame_io_q <= IO_WDATA;         // [R4] [R10]
            IDX_EMS_PAGE_RANGE_EXTENSION: cfg_range_q    <= IO_WDATA;         // [R7] [R8]
            IDX_MISC_EMS_SIZE:            cfg_size_q     <= IO_WDATA;         // [R2]
            default:                      cfg_size_q     <= cfg_size_q;
         endcase
      end
   end

   // ****************************************
   // Page register select
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         page_sel_q <= 2'b00;
      else if (page_wr_sel)
         page_sel_q <= IO_WDATA[1:0];                                         // [R11]
   end

   epf_page_mem u_pages
   (
      .clk       (SYS_CLK),
      .reset_n   (RESET_N),
      .wr_en     (page_wr_data),
      .wr_sel    (page_sel_q),
      .wr_data   (IO_WDATA),
      .rd_a_sel  (page_sel_q),
      .rd_a_data (page_a_data),
      .rd_b_sel  (frame_off[15:14]),
      .rd_b_data (page_b_data)
   );

   // ****************************************
   // Read answer
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cfg_rd_q  <= UNMAPPED_READ;
         page_rd_q <= 1'b0;
         IO_ACK    <= 1'b0;
      end
      else
      begin
         IO_ACK    <= (data_ok && IO_RD) || (page_io && IO_RD);
         page_rd_q <= page_io && IO_RD && (IO_ADDR[0] == PAGE_PORT_DATA[0]);
         if (page_io && IO_RD && !IO_ADDR[0])
            cfg_rd_q <= {6'b000000, page_sel_q};
         else if (data_ok && IO_RD)
         begin
            case (index_q)
               IDX_DRAM_CONFIG_EMS_ENABLE:   cfg_rd_q <= cfg_enable_q;
               IDX_EMS_FRAME_AND_IO_BASE:    cfg_rd_q <= cfg_frame_io_q;
               IDX_EMS_PAGE_RANGE_EXTENSION: cfg_rd_q <= cfg_range_q;
               IDX_MISC_EMS_SIZE:            cfg_rd_q <= cfg_size_q;
               default:                      cfg_rd_q <= UNMAPPED_READ;
            endcase
         end
      end
   end

   assign IO_RDATA = page_rd_q ? page_a_data : cfg_rd_q;

   // ****************************************
   // Address mapping pipeline
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         addr_s1_q  <= 24'h000000;
         valid_s1_q <= 1'b0;
         hit_s1_q   <= 1'b0;
         page_s1_q  <= 2'b00;
      end
      else
      begin
         addr_s1_q  <= MEM_ADDR;
         valid_s1_q <= MEM_VALID;
         hit_s1_q   <= MEM_VALID && cfg_enable_q[EMS_ENABLE_BIT] && decode_ok && in_frame; // [R1] [R14] [R15]
         page_s1_q  <= frame_off[15:14];                                      // [R5]
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         MAP_ADDR  <= 24'h000000;
         MAP_VALID <= 1'b0;
         MAP_HIT   <= 1'b0;
      end
      else
      begin
         MAP_VALID <= valid_s1_q;
         if (hit_s1_q && (mapped < ems_limit) && (mapped < DRAM_LIMIT))     // [R3] [R12] [R14]
         begin
            MAP_ADDR <= mapped;
            MAP_HIT  <= 1'b1;
         end
         else
         begin
            MAP_ADDR <= addr_s1_q;                                            // [R14]
            MAP_HIT  <= 1'b0;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   idx_consumed_a: assert property (is_data |=> idx_state_q == IDX_EMPTY) // [R13]
      else $error("index stayed armed after data access");
   enable_gate_a: assert property (MAP_HIT |-> $past(cfg_enable_q[EMS_ENABLE_BIT], 2)) // [R1]
      else $error("mapped while disabled");
   above_first_mb_a: assert property (MAP_HIT |-> MAP_ADDR >= ONE_MB) // [R3]
      else $error("mapped into first megabyte");
   dram_limit_a: assert property (MAP_HIT |-> MAP_ADDR < DRAM_LIMIT) // [R12]
      else $error("mapped beyond on-board memory");
   size_bound_a: assert property (MAP_HIT |-> MAP_ADDR < $past(ems_limit)) // [R2]
      else $error("mapped beyond sized expanded memory");
   frame_window_a: assert property (MAP_HIT |-> $past(MEM_ADDR[19:0], 2) >= FRAME_PHYS_LO) // [R6]
      else $error("hit below frame segment");
   reserved_code_a: assert property (frame_code > FRAME_CODE_MAX |=> !hit_s1_q) // [R15]
      else $error("decode with reserved base code");
   pass_through_a: assert property (MAP_VALID && !MAP_HIT |-> MAP_ADDR == $past(MEM_ADDR, 2)) // [R14]
      else $error("unmapped access altered");
   page_ack_a: assert property (IO_RD && !page_io && !data_ok |=> !IO_ACK) // [R11]
      else $error("answer at unselected port");
   map_latency_a: assert property (MEM_VALID |-> ##2 MAP_VALID) // [R14]
      else $error("mapped answer missing");
   cfg_ack_a: assert property (data_ok && IO_RD |=> IO_ACK) // [R13]
      else $error("armed data read not answered");

   map_hit_c:    cover property (MEM_VALID ##2 MAP_HIT);
   cfg_write_c:  cover property (is_idx_wr ##1 (data_ok && IO_WR));
   page_write_c: cover property (page_wr_sel ##[1:4] page_wr_data);
   cfg_read_c:   cover property ((data_ok && IO_RD) ##1 IO_ACK);
   map_pass_c:   cover property (MEM_VALID ##2 (MAP_VALID && !MAP_HIT));

endmodule

`default_nettype wire

/* File: tb/epf_host_model.sv */
/*
 * Host processor model: byte I/O cycles and memory address strobes.
 * Assumes every strobe is launched at a falling edge of the clock.
 */
`timescale 1ns/1ns
`default_nettype none

module epf_host_model
(
   input  wire logic        clk,
   output logic      [15:0] io_addr,
   output logic             io_wr,
   output logic             io_rd,
   output logic      [7:0]  io_wdata,
   input  wire logic [7:0]  io_rdata,
   input  wire logic        io_ack,
   output logic      [23:0] mem_addr,
   output logic             mem_valid,
   input  wire logic [23:0] map_addr,
   input  wire logic        map_valid,
   input  wire logic        map_hit
);
   import epf_pkg::*;

   // ****************************************
   // Bus cycles
   // ****************************************
   initial
   begin
      io_addr   = 16'h0000;
      io_wr     = 1'b0;
      io_rd     = 1'b0;
      io_wdata  = 8'h00;
      mem_addr  = 24'h000000;
      mem_valid = 1'b0;
   end

   // Released lines show the inverse of the last value
   task automatic io_wr_t(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr  = a;
      io_wdata = d;
      io_wr    = 1'b1;
      @(negedge clk);
      io_wr    = 1'b0;
      io_addr  = ~a;
      io_wdata = ~d;
   endtask

   task automatic io_rd_t(input logic [15:0] a, output logic [7:0] d, output logic ok);
      @(negedge clk);
      io_addr = a;
      io_rd   = 1'b1;
      @(negedge clk);
      ok      = io_ack;
      d       = io_rdata;
      io_rd   = 1'b0;
      io_addr = ~a;
   endtask

   task automatic mem_t(input logic [23:0] a, output logic [23:0] m, output logic h, output logic v);
      @(negedge clk);
      mem_addr  = a;
      mem_valid = 1'b1;
      @(negedge clk);
      mem_valid = 1'b0;
      mem_addr  = ~a;
      @(negedge clk);
      v = map_valid;
      m = map_addr;
      h = map_hit;
   endtask

   task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
      io_wr_t(CFG_INDEX_PORT, i);
      io_wr_t(CFG_DATA_PORT, d);
   endtask

   task automatic cfg_rd(input logic [7:0] i, output logic [7:0] d, output logic ok);
      io_wr_t(CFG_INDEX_PORT, i);
      io_rd_t(CFG_DATA_PORT, d, ok);
   endtask
endmodule

`default_nettype wire

/* File: tb/epf_map_cfg_tb.sv */
/*
 * Self-checking bench for the page-frame map configuration block.
 * Assumes the host model drives all processor cycles.
 */
`timescale 1ns/1ns
`default_nettype none

module epf_map_cfg_tb;
   import epf_pkg::*;

   logic        clk, rst_n, io_wr, io_rd, io_ack, mem_valid, map_valid, map_hit;
   logic [15:0] io_addr, pp;
   logic [7:0]  io_wdata, io_rdata, d, ext, tmp;
   logic [23:0] mem_addr, map_addr, m, lo, a;
   logic [24:0] e;
   logic        ok, h, v, en, iov;
   logic [3:0]  fc, ioc;
   logic [2:0]  sz;
   logic [7:0]  pg[4];
   logic [3:0]  codes[7] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'hA, 4'hB, 4'hE};
   logic [7:0]  idx[4] = '{8'h6B, 8'h6D, 8'h6E, 8'h6F};
   logic [7:0]  cv[4];
   logic [31:0] seed;
   int          failures, n_compared;

   epf_map_cfg i_epf_map_cfg (.SYS_CLK(clk), .RESET_N(rst_n), .IO_ADDR(io_addr), .IO_WR(io_wr),
      .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_ACK(io_ack), .MEM_ADDR(mem_addr),
      .MEM_VALID(mem_valid), .MAP_ADDR(map_addr), .MAP_VALID(map_valid), .MAP_HIT(map_hit));

   epf_host_model i_epf_host_model (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack), .mem_addr(mem_addr),
      .mem_valid(mem_valid), .map_addr(map_addr), .map_valid(map_valid), .map_hit(map_hit));

   // ****************************************
   // Helpers
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x)
      begin
         $display("BAD %s expected %h seen %h", nm, x, g);
         failures++;
      end
   endtask

   function automatic logic [24:0] exp_map(input logic [23:0] ad);
      logic [1:0]  p, s;
      logic [23:0] mp, lim;
      p   = 2'((ad - lo) >> 14);
      s   = 2'(ext >> (6 - 2 * p));
      mp  = (s == 2'h0 ? 24'h100000 : 24'(s) << 21) + {3'h0, pg[p][6:0], ad[13:0]};
      lim = sz == 3'h0 ? 24'h180000 : 24'(sz) * 24'h100000 + 24'h100000;
      if (en && iov && ad >= lo && ad < lo + 24'h10000 && mp < lim && mp < 24'h800000)
         return {1'b1, mp};
      return {1'b0, ad};
   endfunction

   task automatic give_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #(40 * 20000);
      failures++;
      give_verdict();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      failures   = 0;
      n_compared = 0;
      seed       = 86;
      rst_n      = 1'b0;
      for (int q = 0; q < 4; q++)
         pg[q] = 8'h00;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         i_epf_host_model.cfg_rd(idx[i], d, ok);
         chk("reset ack", 1, ok);
         chk("reset value", 8'h00, d);
      end
      i_epf_host_model.io_rd_t(CFG_DATA_PORT, d, ok);
      chk("unarmed data ack", 0, ok);
      i_epf_host_model.cfg_rd(8'h60, d, ok);
      chk("unmapped index", 9'h100, {ok, d});
      for (int k = 0; k < 40; k++)
      begin
         cv[0] = 8'(rnd());
         fc    = 4'(rnd() % 10);
         ioc   = k % 9 == 8 ? 4'h3 : codes[rnd() % 7];
         cv[1] = {fc, ioc};
         cv[2] = 8'(rnd());
         cv[3] = 8'(rnd());
         if (k % 4 == 0)
            cv[3][7:5] = 3'h7;
         en    = cv[0][4];
         ext   = cv[2];
         sz    = cv[3][7:5];
         iov   = fc <= 4'h8 && ioc inside {4'h0, 4'h1, 4'h5, 4'h6, 4'hA, 4'hB, 4'hE};
         lo    = 24'hC0000 + 24'(fc) * 24'h4000;
         for (int i = 0; i < 4; i++)
         begin
            i_epf_host_model.cfg_wr(idx[i], cv[i]);
            i_epf_host_model.cfg_rd(idx[i], d, ok);
            chk("config readback", {1'b1, cv[i]}, {ok, d});
         end
         pp = {8'h02, ioc, 4'h8};
         for (int q = 0; q < 4; q++)
         begin
            tmp = 8'(rnd()) & 8'h7F;
            i_epf_host_model.io_wr_t(pp, 8'(q));
            i_epf_host_model.io_wr_t(pp + 16'h1, tmp);
            if (iov)
               pg[q] = tmp;
            i_epf_host_model.io_rd_t(pp + 16'h1, d, ok);
            chk("page data", iov ? {1'b1, tmp} : 9'h0, {ok, ok ? d : 8'h00});
            i_epf_host_model.io_rd_t(pp, d, ok);
            chk("page select", iov ? {1'b1, 8'(q)} : 9'h0, {ok, ok ? d : 8'h00});
         end
         i_epf_host_model.io_rd_t({8'h02, ioc ^ 4'h1, 4'h9}, d, ok);
         chk("other pair ack", 0, ok);
         for (int j = 0; j < 8; j++)
         begin
            a = j == 0 ? lo : j == 1 ? lo + 24'hFFFF : j == 7 ? 24'(rnd()) : lo - 24'h4000 + 24'(rnd() % 24'h18000);
            e = exp_map(a);
            i_epf_host_model.mem_t(a, m, h, v);
            chk("map valid", 1, v);
            chk("map result", e, {h, m});
         end
      end
      give_verdict();
   end
endmodule

`default_nettype wire
